// ==== logic/nsc_node_switch_config.sv ====
// Purpose: Configuration register set and routing lookup of the node packet switch.
// Assumes: Requests arrive as single-cycle strobes synchronous to sys_clk.
// Notes:   Each request is answered exactly one cycle later.
//
// How it works
// - The low direction table holds eight zero-reset nibbles, nibble k serving mismatch bit k.
// - The high direction table holds eight zero-reset nibbles for mismatch bits 8 to 15, top nibble for bit 15.
// - Each packet destination is compared with the local identifier and routed by the table.
// - The most significant mismatching bit chooses the direction when several bits differ.
// - With debug call enabled, a low level on the debug pin raises a debug call to the core.
// - With pin driving enabled, the pin is pulled low in debug mode and otherwise left undriven.
// - Once the lock bit is written, writes to the node configuration and link registers are ignored.
// - Node configuration bit 0 selects one-byte headers, zero selecting three-byte headers.
// - The node identifier is a writable zero-reset 16-bit field with reserved upper bits.
// - The identification word carries chip id, captured boot pins, revision and version.
// - Each configuration access names a register number and is answered from the map.
// - The driven debug pin stays released until a breakpoint puts the node in debug mode.
`timescale 1ns/1ps
`include "nsc_map.svh"

module nsc_node_switch_config
    import nsc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Configuration requests
    input  wire logic        cfgReqValid,
    input  wire logic        cfgReqWrite,
    input  wire logic [7:0]  cfgReqReg,
    input  wire logic [31:0] cfgReqData,
    // Configuration answers
    output logic             cfgAckValid,
    output logic             cfgAckFail,
    output logic [31:0]      cfgAckData,
    // Packet routing
    input  wire logic        pktValid,
    input  wire logic [15:0] pktDest,
    output logic             routeValid,
    output logic             routeLocal,
    output logic [3:0]       routeDir,
    // Switch mode
    output logic             singleByteHeader,
    // Debug pin and core
    input  wire logic        debugPinIn,
    output logic             debugPinOut,
    output logic             debugPinOe,
    input  wire logic        nodeInDebug,
    output logic             debug_call,
    // Boot select pins
    input  wire logic        boot_select_pin_0,
    input  wire logic        boot_select_pin_1
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    nsc_word_t nodeCfg;
    nsc_word_t next_nodeCfg;
    logic [15:0] nodeId;
    logic [15:0] next_nodeId;
    nsc_word_t pllSettings;
    nsc_word_t next_pllSettings;
    nsc_word_t clkDivider;
    nsc_word_t next_clkDivider;
    nsc_word_t refClock;
    nsc_word_t next_refClock;
    nsc_word_t dirsLow;
    nsc_word_t next_dirsLow;
    nsc_word_t dirsHigh;
    nsc_word_t next_dirsHigh;
    logic [1:0] debugCfg;
    logic [1:0] next_debugCfg;
    nsc_word_t linkRegs [`NSC_LINK_SLOTS];
    logic [1:0] bootPins;
    logic [1:0] next_bootPins;
    logic       bootCaught;
    logic       next_bootCaught;

    logic        next_cfgAckValid;
    logic        next_cfgAckFail;
    nsc_word_t   next_cfgAckData;
    logic        next_routeValid;
    logic        next_routeLocal;
    nsc_dir_t    next_routeDir;
    logic        next_debugPinOe;
    logic        next_debugCall;

    // ----------------------------------------------------------------
    // Link register decode
    // ----------------------------------------------------------------
    logic       linkHit;
    logic [4:0] linkSlot;
    logic       locked;
    logic       wrStrobe;

    assign locked   = nodeCfg[`NSC_CFG_LOCK_BIT];
    assign wrStrobe = cfgReqValid && cfgReqWrite;

    always_comb begin
        linkHit  = 1'b0;
        linkSlot = 5'd0;
        if (cfgReqReg >= `NSC_REG_LINK_STAT && cfgReqReg < `NSC_REG_LINK_STAT + `NSC_LINK_GRP_WIDE) begin
            linkHit  = 1'b1;
            linkSlot = {2'b00, cfgReqReg[2:0]};
        end else if (cfgReqReg >= `NSC_REG_PROCESSOR_LINK_STAT
                     && cfgReqReg < `NSC_REG_PROCESSOR_LINK_STAT + `NSC_LINK_GRP_PROCESSOR_LINK) begin
            linkHit  = 1'b1;
            linkSlot = `NSC_SLOT_PROCESSOR_LINK + {3'b000, cfgReqReg[1:0]};
        end else if (cfgReqReg >= `NSC_REG_LINK_CFG
                     && cfgReqReg < `NSC_REG_LINK_CFG + `NSC_LINK_GRP_WIDE) begin
            linkHit  = 1'b1;
            linkSlot = `NSC_SLOT_LINK_CFG + {2'b00, cfgReqReg[2:0]};
        end else if (cfgReqReg >= `NSC_REG_STATIC_LINK
                     && cfgReqReg < `NSC_REG_STATIC_LINK + `NSC_LINK_GRP_WIDE) begin
            linkHit  = 1'b1;
            linkSlot = `NSC_SLOT_STATIC + {2'b00, cfgReqReg[2:0]};
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_comb begin
        next_nodeCfg     = nodeCfg;
        next_nodeId      = nodeId;
        next_pllSettings = pllSettings;
        next_clkDivider  = clkDivider;
        next_refClock    = refClock;
        next_dirsLow     = dirsLow;
        next_dirsHigh    = dirsHigh;
        next_debugCfg    = debugCfg;
        if (wrStrobe) begin
            unique case (cfgReqReg)
                `NSC_REG_NODE_CFG: begin
                    if (!locked) begin
                        next_nodeCfg[`NSC_CFG_LOCK_BIT] = cfgReqData[`NSC_CFG_LOCK_BIT];
                        next_nodeCfg[`NSC_CFG_HDR_BIT]  = cfgReqData[`NSC_CFG_HDR_BIT];
                    end
                end
                `NSC_REG_NODE_ID:    next_nodeId      = cfgReqData[15:0];
                `NSC_REG_PLL:        next_pllSettings = cfgReqData;
                `NSC_REG_CLK_DIV:    next_clkDivider  = cfgReqData;
                `NSC_REG_REF_CLK:    next_refClock    = cfgReqData;
                `NSC_REG_DIRS_LOW:   next_dirsLow     = cfgReqData;
                `NSC_REG_DIRS_HIGH:  next_dirsHigh    = cfgReqData;
                `NSC_REG_DEBUG_PIN:  next_debugCfg    = cfgReqData[1:0];
                default:             next_debugCfg    = debugCfg;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            nodeCfg     <= `NSC_RESET_WORD;
            nodeId      <= 16'h0000;
            pllSettings <= `NSC_RESET_WORD;
            clkDivider  <= `NSC_RESET_WORD;
            refClock    <= `NSC_RESET_WORD;
            dirsLow     <= `NSC_RESET_WORD;
            dirsHigh    <= `NSC_RESET_WORD;
            debugCfg    <= 2'b00;
        end else begin
            nodeCfg     <= next_nodeCfg;
            nodeId      <= next_nodeId;
            pllSettings <= next_pllSettings;
            clkDivider  <= next_clkDivider;
            refClock    <= next_refClock;
            dirsLow     <= next_dirsLow;
            dirsHigh    <= next_dirsHigh;
            debugCfg    <= next_debugCfg;
        end
    end

    // ----------------------------------------------------------------
    // Link registers, one slot per generated entry
    // ----------------------------------------------------------------
    for (genvar s = 0; s < `NSC_LINK_SLOTS; s++) begin : g_link
        nsc_word_t next_slot;
        always_comb begin
            next_slot = linkRegs[s];
            if (wrStrobe && linkHit && !locked && linkSlot == 5'(s)) begin
                next_slot = cfgReqData;
            end
        end
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                linkRegs[s] <= `NSC_RESET_WORD;
            end else begin
                linkRegs[s] <= next_slot;
            end
        end
    end

    // ----------------------------------------------------------------
    // Boot pin capture after reset release
    // ----------------------------------------------------------------
    always_comb begin
        next_bootCaught = 1'b1;
        next_bootPins   = bootCaught ? bootPins : {boot_select_pin_1, boot_select_pin_0};
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bootCaught <= 1'b0;
            bootPins   <= 2'b00;
        end else begin
            bootCaught <= next_bootCaught;
            bootPins   <= next_bootPins;
        end
    end

    // ----------------------------------------------------------------
    // Configuration answers
    // ----------------------------------------------------------------
    always_comb begin
        next_cfgAckValid = cfgReqValid;
        next_cfgAckFail  = 1'b0;
        next_cfgAckData  = `NSC_RESET_WORD;
        if (cfgReqValid) begin
            if (linkHit) begin
                next_cfgAckData = cfgReqWrite ? `NSC_RESET_WORD : linkRegs[linkSlot];
            end else begin
                unique case (cfgReqReg)
                    `NSC_REG_IDENT: next_cfgAckData = {`NSC_CHIP_ID, 6'b000000, bootPins,
                                                       `NSC_SW_REVISION, `NSC_SW_VERSION};
                    `NSC_REG_SW_DESC:    next_cfgAckData = `NSC_SW_DESC_VALUE;
                    `NSC_REG_NODE_CFG:   next_cfgAckData = {nodeCfg[31], 30'h0000_0000, nodeCfg[0]};
                    `NSC_REG_NODE_ID:    next_cfgAckData = {16'h0000, nodeId};
                    `NSC_REG_PLL:        next_cfgAckData = pllSettings;
                    `NSC_REG_CLK_DIV:    next_cfgAckData = clkDivider;
                    `NSC_REG_REF_CLK:    next_cfgAckData = refClock;
                    `NSC_REG_DIRS_LOW:   next_cfgAckData = dirsLow;
                    `NSC_REG_DIRS_HIGH:  next_cfgAckData = dirsHigh;
                    `NSC_REG_DEBUG_PIN:  next_cfgAckData = {30'h0000_0000, debugCfg};
                    `NSC_REG_DEBUG_SRC:  next_cfgAckData = `NSC_RESET_WORD;
                    default:             next_cfgAckFail = 1'b1;
                endcase
                if (cfgReqWrite) begin
                    next_cfgAckData = `NSC_RESET_WORD;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Routing lookup
    // ----------------------------------------------------------------
    always_comb begin
        logic [15:0] diff;
        logic [63:0] table_all;
        diff          = pktDest ^ nodeId;
        table_all     = {dirsHigh, dirsLow};
        next_routeDir = 4'h0;
        // Higher bits are visited last so they override lower ones.
        for (int k = 0; k < 16; k++) begin
            if (diff[k]) begin
                next_routeDir = table_all[4*k +: 4];
            end
        end
        next_routeValid = pktValid;
        next_routeLocal = pktValid && (diff == 16'h0000);
    end

    // ----------------------------------------------------------------
    // Debug pin
    // ----------------------------------------------------------------
    always_comb begin
        next_debugPinOe = debugCfg[`NSC_DBG_DRIVE_BIT] && nodeInDebug;
        next_debugCall  = debugCfg[`NSC_DBG_CALL_BIT] && !debugPinIn;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfgAckValid      <= 1'b0;
            cfgAckFail       <= 1'b0;
            cfgAckData       <= `NSC_RESET_WORD;
            routeValid       <= 1'b0;
            routeLocal       <= 1'b0;
            routeDir         <= 4'h0;
            singleByteHeader <= 1'b0;
            debugPinOut      <= 1'b0;
            debugPinOe       <= 1'b0;
            debug_call       <= 1'b0;
        end else begin
            cfgAckValid      <= next_cfgAckValid;
            cfgAckFail       <= next_cfgAckFail;
            cfgAckData       <= next_cfgAckData;
            routeValid       <= next_routeValid;
            routeLocal       <= next_routeLocal;
            routeDir         <= next_routeDir;
            singleByteHeader <= next_nodeCfg[`NSC_CFG_HDR_BIT];
            debugPinOut      <= 1'b0;
            debugPinOe       <= next_debugPinOe;
            debug_call       <= next_debugCall;
        end
    end

endmodule : nsc_node_switch_config

// ==== logic/nsc_map.svh ====
// Purpose: Register numbers, field positions and reset values of the node switch configuration block.
// Assumes: Registers are addressed by their configuration register number.
// Notes:   Definitions only.
`ifndef NSC_MAP_SVH
`define NSC_MAP_SVH

// ----------------------------------------------------------------
// Register numbers
// ----------------------------------------------------------------
`define NSC_REG_IDENT        8'h00
`define NSC_REG_SW_DESC      8'h01
`define NSC_REG_NODE_CFG     8'h04
`define NSC_REG_NODE_ID      8'h05
`define NSC_REG_PLL          8'h06
`define NSC_REG_CLK_DIV      8'h07
`define NSC_REG_REF_CLK      8'h08
`define NSC_REG_DIRS_LOW     8'h0C
`define NSC_REG_DIRS_HIGH    8'h0D
`define NSC_REG_DEBUG_PIN    8'h10
`define NSC_REG_DEBUG_SRC    8'h1F
`define NSC_REG_LINK_STAT    8'h20
`define NSC_REG_PROCESSOR_LINK_STAT   8'h40
`define NSC_REG_LINK_CFG     8'h80
`define NSC_REG_STATIC_LINK  8'hA0

// ----------------------------------------------------------------
// Link register groups: entry count and slot base in the array
// ----------------------------------------------------------------
`define NSC_LINK_GRP_WIDE    8'h08
`define NSC_LINK_GRP_PROCESSOR_LINK   8'h04
`define NSC_LINK_SLOTS       28
`define NSC_SLOT_PROCESSOR_LINK       5'd8
`define NSC_SLOT_LINK_CFG    5'd12
`define NSC_SLOT_STATIC      5'd20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define NSC_CFG_LOCK_BIT     31
`define NSC_CFG_HDR_BIT      0
`define NSC_DBG_CALL_BIT     1
`define NSC_DBG_DRIVE_BIT    0

// ----------------------------------------------------------------
// Reset values and identity fields (identity values are arbitrary)
// ----------------------------------------------------------------
`define NSC_RESET_WORD       32'h0000_0000
`define NSC_CHIP_ID          8'h5A
`define NSC_SW_REVISION      8'h01
`define NSC_SW_VERSION       8'h02
`define NSC_SW_DESC_VALUE    32'h0000_0101

`endif

// ==== logic/nsc_pkg.sv ====
// Purpose: Types shared by the node switch configuration block.
// Assumes: Nothing beyond the register map header.
// Notes:   Direction codes are four bits wide.
package nsc_pkg;

    typedef logic [31:0] nsc_word_t;
    typedef logic [3:0]  nsc_dir_t;

endpackage : nsc_pkg

// ==== testbench/nsc_node_switch_config_checker.sv ====
// Purpose: Port-level assertions for the node switch configuration block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Bound to the design at the foot of this file.
`timescale 1ns/1ps

module nsc_checker
    import nsc_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // Configuration bus
    input wire logic        cfgReqValid,
    input wire logic        cfgReqWrite,
    input wire logic [7:0]  cfgReqReg,
    input wire logic        cfgAckValid,
    input wire logic        cfgAckFail,
    input wire logic [31:0] cfgAckData,
    // Routing and debug pin
    input wire logic        pktValid,
    input wire logic        routeValid,
    input wire logic        routeLocal,
    input wire logic [3:0]  routeDir,
    input wire logic        debugPinIn,
    input wire logic        debugPinOut,
    input wire logic        debugPinOe,
    input wire logic        nodeInDebug,
    input wire logic        debug_call
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_ack_follows: assert property (cfgReqValid |=> cfgAckValid)
        else $error("Request was not answered one cycle later.");
    a_ack_quiet: assert property (!cfgReqValid |=> !cfgAckValid && cfgAckData == 32'h0000_0000)
        else $error("Answer appeared without a request.");
    a_write_nodata: assert property (cfgReqValid && cfgReqWrite |=> cfgAckData == 32'h0000_0000)
        else $error("Write answer carried data.");
    a_unmapped_fail: assert property (cfgReqValid && cfgReqReg == 8'h02 |=> cfgAckFail)
        else $error("Unmapped register was not refused.");
    a_mapped_ok: assert property (cfgReqValid && cfgReqReg == 8'h0C |=> !cfgAckFail)
        else $error("Mapped register was refused.");
    a_route_timing: assert property (pktValid |=> routeValid)
        else $error("Route result strobe is missing.");
    a_route_quiet: assert property (!pktValid |=> !routeValid)
        else $error("Route result strobe without a packet.");
    a_local_dir: assert property (routeValid && routeLocal |-> routeDir == 4'h0)
        else $error("Local packet was given a direction.");
    a_pin_release: assert property (!nodeInDebug |=> !debugPinOe)
        else $error("Debug pin driven outside debug mode.");
    a_pin_low: assert property (debugPinOe |-> !debugPinOut)
        else $error("Debug pin driven high.");
    a_call_needs_low: assert property (debugPinIn |=> !debug_call)
        else $error("Debug call raised while pin high.");

    c_fail: cover property (cfgAckValid && cfgAckFail);
    c_route: cover property (routeValid && !routeLocal);
    c_call: cover property (debug_call);
    c_drive: cover property (debugPinOe);
endmodule : nsc_checker

bind nsc_node_switch_config nsc_checker u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .cfgReqValid(cfgReqValid), .cfgReqWrite(cfgReqWrite),
    .cfgReqReg(cfgReqReg), .cfgAckValid(cfgAckValid), .cfgAckFail(cfgAckFail), .cfgAckData(cfgAckData),
    .pktValid(pktValid), .routeValid(routeValid), .routeLocal(routeLocal), .routeDir(routeDir),
    .debugPinIn(debugPinIn), .debugPinOut(debugPinOut), .debugPinOe(debugPinOe),
    .nodeInDebug(nodeInDebug), .debug_call(debug_call)
);

// ==== testbench/nsc_requester.sv ====
// Purpose: Model of a core or debugger issuing configuration transactions.
// Assumes: Answers come one cycle after the request is taken.
// Notes:   Idle request lines show the inverse of the last value.
`timescale 1ns/1ps

module nsc_requester
    import nsc_pkg::*;
(
    // Clock
    input  wire logic        sys_clk,
    // Requests
    output logic             cfgReqValid,
    output logic             cfgReqWrite,
    output logic [7:0]       cfgReqReg,
    output logic [31:0]      cfgReqData,
    // Answers
    input  wire logic        cfgAckValid,
    input  wire logic        cfgAckFail,
    input  wire logic [31:0] cfgAckData
);
    initial begin
        cfgReqValid = 1'b0;
        cfgReqWrite = 1'b0;
        cfgReqReg   = 8'h00;
        cfgReqData  = 32'h0000_0000;
    end

    task automatic access(input logic wr, input logic [7:0] num, input nsc_word_t wdata,
                          output nsc_word_t rdata, output logic fail, output logic acked);
        @(negedge sys_clk);
        cfgReqValid = 1'b1;
        cfgReqWrite = wr;
        cfgReqReg   = num;
        cfgReqData  = wdata;
        @(negedge sys_clk);
        rdata       = cfgAckData;
        fail        = cfgAckFail;
        acked       = cfgAckValid;
        cfgReqValid = 1'b0;
        cfgReqWrite = ~wr;
        cfgReqReg   = ~num;
        cfgReqData  = ~wdata;
    endtask : access
endmodule : nsc_requester

// ==== testbench/nsc_node_switch_config_tb_top.sv ====
// Purpose: Self-checking bench for the node switch configuration block.
// Assumes: Inputs change at the falling edge of sys_clk.
// Notes:   Random tables and identifiers come from a fixed seed.
`timescale 1ns/1ps
`include "nsc_map.svh"

module nsc_node_switch_config_tb_top;
    import nsc_pkg::*;

    logic        sys_clk, reset_n, cfgReqValid, cfgReqWrite, cfgAckValid, cfgAckFail;
    logic [7:0]  cfgReqReg;
    logic [31:0] cfgReqData, cfgAckData;
    logic        pktValid, routeValid, routeLocal, singleByteHeader, debugPinIn, debugPinOut;
    logic        debugPinOe, nodeInDebug, debug_call, boot0, boot1, extLow, fl, ak;
    logic [15:0] pktDest, nodeId, d;
    logic [3:0]  routeDir;
    nsc_word_t   rd, v, lo, hi;
    int          badCount, totalChecks, seed;
    logic [7:0]  resetRegs [6] = '{8'h04, 8'h05, 8'h0C, 8'h0D, 8'h10, 8'h1F};
    logic [7:0]  badRegs [6]   = '{8'h02, 8'h09, 8'h2A, 8'h44, 8'h88, 8'hB0};
    logic [7:0]  rwRegs [7]    = '{8'h06, 8'h07, 8'h08, 8'h27, 8'h43, 8'h87, 8'hA7};
    nsc_word_t   rwVals [7];

    // The shared pin has a pull-up; any driver pulls it low.
    assign debugPinIn = !((debugPinOe && !debugPinOut) || extLow);

    nsc_node_switch_config u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .cfgReqValid(cfgReqValid),
        .cfgReqWrite(cfgReqWrite), .cfgReqReg(cfgReqReg), .cfgReqData(cfgReqData), .cfgAckValid(cfgAckValid),
        .cfgAckFail(cfgAckFail), .cfgAckData(cfgAckData), .pktValid(pktValid), .pktDest(pktDest),
        .routeValid(routeValid), .routeLocal(routeLocal), .routeDir(routeDir),
        .singleByteHeader(singleByteHeader), .debugPinIn(debugPinIn), .debugPinOut(debugPinOut),
        .debugPinOe(debugPinOe), .nodeInDebug(nodeInDebug), .debug_call(debug_call),
        .boot_select_pin_0(boot0), .boot_select_pin_1(boot1));

    nsc_requester u_req (.sys_clk(sys_clk), .cfgReqValid(cfgReqValid), .cfgReqWrite(cfgReqWrite),
        .cfgReqReg(cfgReqReg), .cfgReqData(cfgReqData), .cfgAckValid(cfgAckValid),
        .cfgAckFail(cfgAckFail), .cfgAckData(cfgAckData));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        #100000;
        badCount++;
        stopTest();
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic acc(input logic wr, input logic [7:0] num, input nsc_word_t wdata);
        u_req.access(wr, num, wdata, rd, fl, ak);
        check("answer strobe", {31'h0, ak}, 32'h1);
    endtask : acc

    task automatic pkt(input logic [15:0] dest);
        @(negedge sys_clk);
        pktValid = 1'b1;
        pktDest  = dest;
        @(negedge sys_clk);
        check("route strobe", {31'h0, routeValid}, 32'h1);
        check("route", {27'h0, routeLocal, routeDir}, expRoute(nodeId, dest, {hi, lo}));
        pktValid = 1'b0;
        pktDest  = ~dest;
    endtask : pkt

    // Later, higher mismatching bits overwrite lower ones.
    function automatic logic [31:0] expRoute(input logic [15:0] id, dest, input logic [63:0] tbl);
        expRoute = 32'h10;
        for (int k = 0; k < 16; k++)
            if (id[k] !== dest[k]) expRoute = {28'h0, tbl[4*k +: 4]};
    endfunction : expRoute

    task automatic stopTest();
        $display("Comparisons %0d, mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stopTest

    initial begin
        seed = $urandom(32'h30c2);
        {reset_n, pktValid, pktDest, nodeInDebug, extLow} = '0;
        {boot1, boot0} = 2'($urandom);
        repeat (8) @(negedge sys_clk);
        reset_n = 1'b1;
        foreach (resetRegs[i]) begin
            acc(0, resetRegs[i], 0);
            check("reset value", rd, 0);
        end
        acc(1, 8'h00, $urandom);
        acc(0, 8'h00, 0);
        check("ident", rd, {`NSC_CHIP_ID, 6'h0, boot1, boot0, `NSC_SW_REVISION, `NSC_SW_VERSION});
        foreach (badRegs[i]) begin
            acc(0, badRegs[i], 0);
            check("unmapped fail", {31'h0, fl}, 32'h1);
        end
        acc(0, 8'h01, 0);
        check("switch description", rd, `NSC_SW_DESC_VALUE);
        // All values are written first so that aliased slots would show up on readback.
        foreach (rwRegs[i]) begin
            rwVals[i] = $urandom;
            acc(1, rwRegs[i], rwVals[i]);
        end
        foreach (rwRegs[i]) begin
            acc(0, rwRegs[i], 0);
            check("rw storage", rd, rwVals[i]);
            check("rw mapped", {31'h0, fl}, 32'h0);
        end
        $display("Test reset and map done");
        for (int r = 0; r < 3; r++) begin
            v = $urandom;
            nodeId = v[15:0];
            lo = $urandom;
            hi = $urandom;
            acc(1, 8'h05, v);
            acc(1, 8'h0C, lo);
            acc(1, 8'h0D, hi);
            acc(0, 8'h05, 0);
            check("node id", rd, {16'h0, nodeId});
            acc(0, 8'h0C, 0);
            check("low table", rd, lo);
            acc(0, 8'h0D, 0);
            check("high table", rd, hi);
            for (int i = 0; i < 20; i++) begin
                d = (i == 0) ? nodeId : (i == 1) ? nodeId ^ 16'h8001 : (i == 2) ? nodeId ^ 16'h0081 : 16'($urandom);
                pkt(d);
            end
        end
        $display("Test routing done");
        acc(1, 8'h10, 32'hFFFF_FFFF);
        acc(0, 8'h10, 0);
        check("debug config", rd, 32'h3);
        nodeInDebug = 1'b1;
        repeat (2) @(negedge sys_clk);
        check("pin drive", {31'h0, debugPinOe}, 32'h1);
        check("debug call", {31'h0, debug_call}, 32'h1);
        acc(1, 8'h10, 32'h2);
        extLow = 1'b1;
        repeat (2) @(negedge sys_clk);
        check("pin released", {31'h0, debugPinOe}, 32'h0);
        check("call from pin", {31'h0, debug_call}, 32'h1);
        acc(1, 8'h10, 32'h1);
        nodeInDebug = 1'b0;
        repeat (2) @(negedge sys_clk);
        check("call off", {31'h0, debug_call}, 32'h0);
        check("pin idle", {31'h0, debugPinOe}, 32'h0);
        extLow = 1'b0;
        $display("Test debug pin done");
        v = $urandom;
        acc(1, 8'h04, {1'b0, v[30:1], 1'b1});
        check("header mode", {31'h0, singleByteHeader}, 32'h1);
        acc(0, 8'h04, 0);
        check("node config", rd, 32'h1);
        acc(1, 8'h04, 0);
        check("header mode", {31'h0, singleByteHeader}, 32'h0);
        acc(1, 8'h20, v);
        acc(1, 8'h04, 32'h8000_0001);
        acc(1, 8'h04, 0);
        acc(1, 8'h20, ~v);
        acc(0, 8'h20, 0);
        check("locked link", rd, v);
        acc(0, 8'h04, 0);
        check("locked config", rd, 32'h8000_0001);
        check("locked header", {31'h0, singleByteHeader}, 32'h1);
        $display("Test lock done");
        // Only a reset clears the lock.
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        acc(0, 8'h04, 0);
        check("lock cleared", rd, 32'h0);
        check("header reset", {31'h0, singleByteHeader}, 32'h0);
        acc(1, 8'h20, ~v);
        acc(0, 8'h20, 0);
        check("unlocked link", rd, ~v);
        $display("Test second reset done");
        stopTest();
    end
endmodule : nsc_node_switch_config_tb_top
